// File: design/ttc_pkg.sv
package ttc_pkg;

    // Register word indices; the byte address is four times the index.
    localparam logic [7:0] TTC_IDX_RUN_FLAGS  = 8'h88;
    localparam logic [7:0] TTC_IDX_MODE_CTRL  = 8'h89;
    localparam logic [7:0] TTC_IDX_T0_LOW     = 8'h8a;
    localparam logic [7:0] TTC_IDX_T1_LOW     = 8'h8b;
    localparam logic [7:0] TTC_IDX_T0_HIGH    = 8'h8c;
    localparam logic [7:0] TTC_IDX_T1_HIGH    = 8'h8d;
    localparam logic [7:0] TTC_IDX_T2_CTRL    = 8'hc8;
    localparam logic [7:0] TTC_IDX_T2_MODE    = 8'hc9;
    localparam logic [7:0] TTC_IDX_RELOAD_LOW = 8'hca;
    localparam logic [7:0] TTC_IDX_RELOAD_HI  = 8'hcb;
    localparam logic [7:0] TTC_IDX_T2_LOW     = 8'hcc;
    localparam logic [7:0] TTC_IDX_T2_HIGH    = 8'hcd;

    localparam logic [7:0] TTC_RESET_BYTE = 8'h00;

    // Timer mode control fields.
    localparam int TTC_MC_TIMER_ONE_PIN_GATING = 7;
    localparam int TTC_MC_CT1   = 6;
    localparam int TTC_MC_M1_HI = 5;
    localparam int TTC_MC_M1_LO = 4;
    localparam int TTC_MC_TIMER_ZERO_PIN_GATING = 3;
    localparam int TTC_MC_CT0   = 2;
    localparam int TTC_MC_M0_HI = 1;
    localparam int TTC_MC_M0_LO = 0;

    // Run and flag register fields.
    localparam int TTC_RF_TF1 = 7;
    localparam int TTC_RF_TR1 = 6;
    localparam int TTC_RF_TF0 = 5;
    localparam int TTC_RF_TR0 = 4;

    // Timer two control fields.
    localparam int TTC_T2_TF2   = 7;
    localparam int TTC_T2_TIMER_TWO_EXTERNAL_FLAG  = 6;
    localparam int TTC_T2_RCLK  = 5;
    localparam int TTC_T2_TX_BAUD_FROM_TIMER_TWO  = 4;
    localparam int TTC_T2_EXEN2 = 3;
    localparam int TTC_T2_TR2   = 2;
    localparam int TTC_T2_CT2   = 1;
    localparam int TTC_T2_CPRL  = 0;

    // Timer two mode control fields.
    localparam int TTC_T2M_OE   = 1;
    localparam int TTC_T2M_UPDOWN_ENABLE = 0;

    // Clock dividers in system clock cycles.
    localparam logic [3:0] TTC_DIV_TIMER = 4'h6;
    localparam logic [3:0] TTC_DIV_T2    = 4'hc;

    localparam logic [4:0]  TTC_PRESCALE_TOP = 5'h1f;
    localparam logic [7:0]  TTC_BYTE_TOP     = 8'hff;
    localparam logic [15:0] TTC_WORD_TOP     = 16'hffff;

    typedef enum logic [1:0] {
        TTC_MODE_13     = 2'b00,
        TTC_MODE_16     = 2'b01,
        TTC_MODE_RELOAD = 2'b10,
        TTC_MODE_SPLIT  = 2'b11
    } ttc_mode_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ttc_av_req_s;

endpackage : ttc_pkg

// File: design/ttc_timers.sv
// The Avalon-MM interface to the registers is this design's own decision.
module ttc_timers
    import ttc_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire ttc_pkg::ttc_av_req_s i_av,
    output logic                      o_waitrequest,
    output logic [31:0]               o_readdata,
    input  wire logic                 i_ext_irq_zero_n,
    input  wire logic                 i_ext_irq_one_n,
    input  wire logic                 i_timer_zero_count_pin,
    input  wire logic                 i_timer_one_count_pin,
    input  wire logic                 i_timer_two_io_pin,
    input  wire logic                 i_timer_two_direction_pin,
    output logic                      o_timer_two_io_pin,
    output logic                      o_timer_two_io_pin_oe,
    output logic                      o_rx_baud_tick,
    output logic                      o_tx_baud_tick,
    output logic                      o_timer_zero_irq,
    output logic                      o_timer_one_irq,
    output logic                      o_timer_two_irq
);
    import ttc_pkg::*;

    logic [7:0]  mode_ctrl;
    logic [7:0]  run_flags;
    logic [7:0]  t2_ctrl;
    logic [1:0]  t2_mode;
    logic [7:0]  tl0, th0, tl1, th1;
    logic [15:0] cnt2, rcap;
    logic [3:0]  div_cnt;
    logic        pin0_q, pin1_q, pin2_q, dir_q;
    logic        wr_fire;
    logic [7:0]  wdat;
    logic [7:0]  rd_byte;
    logic        en2, en6, en12;
    logic        fall0, fall1, fall2, fall_dir;
    logic        tick0, tick1, tick2;
    logic        t0_ovf, t0h_ovf, t1_ovf;
    logic [7:0]  next_tl0, next_th0, next_tl1, next_th1;
    logic [15:0] next_cnt2, next_rcap;
    logic        t2_ovf, set_tf2, tog_timer_two_external_flag, set_timer_two_external_flag;
    logic        baud, clkout, updown, capture;
    ttc_mode_e   t0_mode, t1_mode;

    function automatic logic [16:0] ttc_step(input ttc_mode_e mode, input logic [7:0] hi, input logic [7:0] lo);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        unique case (mode)
            TTC_MODE_13:
            begin
                if (lo[4:0] == TTC_PRESCALE_TOP)
                begin
                    r = {hi == TTC_BYTE_TOP, hi + 8'h01, lo[7:5], 5'h00};
                end
                else
                begin
                    r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                end
            end
            TTC_MODE_16:
            begin
                r = {{hi, lo} == TTC_WORD_TOP, {hi, lo} + 16'h0001};
            end
            TTC_MODE_RELOAD:
            begin
                r = (lo == TTC_BYTE_TOP) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
            end
            TTC_MODE_SPLIT:
            begin
                r = {1'b0, hi, lo};
            end
        endcase
        return r;
    endfunction : ttc_step

    // Bus slave: one wait cycle, then the answer with waitrequest low.
    assign wr_fire = i_av.write && !o_waitrequest && i_av.byteenable[0];
    assign wdat    = i_av.writedata[7:0];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_waitrequest <= 1'b1;
        else if ((i_av.read || i_av.write) && o_waitrequest)
            o_waitrequest <= 1'b0;
        else
            o_waitrequest <= 1'b1;
    end

    always_comb
    begin
        unique case (i_av.address)
            TTC_IDX_RUN_FLAGS:  rd_byte = run_flags;
            TTC_IDX_MODE_CTRL:  rd_byte = mode_ctrl;
            TTC_IDX_T0_LOW:     rd_byte = tl0;
            TTC_IDX_T1_LOW:     rd_byte = tl1;
            TTC_IDX_T0_HIGH:    rd_byte = th0;
            TTC_IDX_T1_HIGH:    rd_byte = th1;
            TTC_IDX_T2_CTRL:    rd_byte = t2_ctrl;
            TTC_IDX_T2_MODE:    rd_byte = {6'h00, t2_mode};
            TTC_IDX_RELOAD_LOW: rd_byte = rcap[7:0];
            TTC_IDX_RELOAD_HI:  rd_byte = rcap[15:8];
            TTC_IDX_T2_LOW:     rd_byte = cnt2[7:0];
            TTC_IDX_T2_HIGH:    rd_byte = cnt2[15:8];
            default:            rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_readdata <= 32'h0000_0000;
        else if (i_av.read && o_waitrequest)
            o_readdata <= {24'h00_0000, rd_byte};
    end

    // Clock dividers and pin edge detection.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || div_cnt == TTC_DIV_T2 - 4'h1)
            div_cnt <= 4'h0;
        else
            div_cnt <= div_cnt + 4'h1;
    end

    assign en2  = div_cnt[0];
    assign en6  = (div_cnt == TTC_DIV_TIMER - 4'h1) || (div_cnt == TTC_DIV_T2 - 4'h1);
    assign en12 = div_cnt == TTC_DIV_T2 - 4'h1;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            pin0_q <= 1'b1;
            pin1_q <= 1'b1;
            pin2_q <= 1'b1;
            dir_q  <= 1'b1;
        end
        else
        begin
            pin0_q <= i_timer_zero_count_pin;
            pin1_q <= i_timer_one_count_pin;
            pin2_q <= i_timer_two_io_pin;
            dir_q  <= i_timer_two_direction_pin;
        end
    end

    assign fall0    = pin0_q && !i_timer_zero_count_pin;
    assign fall1    = pin1_q && !i_timer_one_count_pin;
    assign fall2    = pin2_q && !i_timer_two_io_pin;
    assign fall_dir = dir_q && !i_timer_two_direction_pin;

    // Timers zero and one.
    assign t0_mode = ttc_mode_e'(mode_ctrl[TTC_MC_M0_HI:TTC_MC_M0_LO]);
    assign t1_mode = ttc_mode_e'(mode_ctrl[TTC_MC_M1_HI:TTC_MC_M1_LO]);
    assign tick0 = run_flags[TTC_RF_TR0] && (!mode_ctrl[TTC_MC_TIMER_ZERO_PIN_GATING] || i_ext_irq_zero_n)
                   && (mode_ctrl[TTC_MC_CT0] ? fall0 : en6);
    assign tick1 = run_flags[TTC_RF_TR1] && (!mode_ctrl[TTC_MC_TIMER_ONE_PIN_GATING] || i_ext_irq_one_n)
                   && (mode_ctrl[TTC_MC_CT1] ? fall1 : en6);

    always_comb
    begin
        t0_ovf   = 1'b0;
        t0h_ovf  = 1'b0;
        next_tl0 = tl0;
        next_th0 = th0;
        if (t0_mode == TTC_MODE_SPLIT)
        begin
            if (tick0)
            begin
                next_tl0 = tl0 + 8'h01;
                t0_ovf   = tl0 == TTC_BYTE_TOP;
            end
            if (run_flags[TTC_RF_TR1] && en6)
            begin
                next_th0 = th0 + 8'h01;
                t0h_ovf  = th0 == TTC_BYTE_TOP;
            end
        end
        else if (tick0)
        begin
            {t0_ovf, next_th0, next_tl0} = ttc_step(t0_mode, th0, tl0);
        end
    end

    always_comb
    begin
        t1_ovf   = 1'b0;
        next_tl1 = tl1;
        next_th1 = th1;
        if (tick1 && t1_mode != TTC_MODE_SPLIT)
        begin
            {t1_ovf, next_th1, next_tl1} = ttc_step(t1_mode, th1, tl1);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            tl0 <= TTC_RESET_BYTE;
            th0 <= TTC_RESET_BYTE;
            tl1 <= TTC_RESET_BYTE;
            th1 <= TTC_RESET_BYTE;
        end
        else
        begin
            tl0 <= (wr_fire && i_av.address == TTC_IDX_T0_LOW) ? wdat : next_tl0;
            th0 <= (wr_fire && i_av.address == TTC_IDX_T0_HIGH) ? wdat : next_th0;
            tl1 <= (wr_fire && i_av.address == TTC_IDX_T1_LOW) ? wdat : next_tl1;
            th1 <= (wr_fire && i_av.address == TTC_IDX_T1_HIGH) ? wdat : next_th1;
        end
    end

    // Control registers; a hardware flag set wins over a software clear.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            mode_ctrl <= TTC_RESET_BYTE;
            run_flags <= TTC_RESET_BYTE;
            t2_mode   <= 2'h0;
        end
        else
        begin
            if (wr_fire && i_av.address == TTC_IDX_MODE_CTRL)
                mode_ctrl <= wdat;
            if (wr_fire && i_av.address == TTC_IDX_T2_MODE)
                t2_mode <= wdat[1:0];
            if (wr_fire && i_av.address == TTC_IDX_RUN_FLAGS)
                run_flags <= {wdat[7:4], 4'h0};
            if (t0_ovf)
                run_flags[TTC_RF_TF0] <= 1'b1;
            if ((t0_mode == TTC_MODE_SPLIT) ? t0h_ovf : t1_ovf)
                run_flags[TTC_RF_TF1] <= 1'b1;
        end
    end

    // Timer two.
    assign baud    = t2_ctrl[TTC_T2_RCLK] || t2_ctrl[TTC_T2_TX_BAUD_FROM_TIMER_TWO];
    assign clkout  = t2_mode[TTC_T2M_OE];
    assign updown  = t2_mode[TTC_T2M_UPDOWN_ENABLE] && !baud && !t2_ctrl[TTC_T2_CPRL];
    assign capture = t2_ctrl[TTC_T2_CPRL] && !baud && !clkout;
    assign tick2   = t2_ctrl[TTC_T2_TR2]
                     && ((t2_ctrl[TTC_T2_CT2] && !clkout) ? fall2 : (clkout || baud) ? en2 : en12);

    always_comb
    begin
        next_cnt2 = cnt2;
        next_rcap = rcap;
        t2_ovf    = 1'b0;
        set_tf2   = 1'b0;
        tog_timer_two_external_flag  = 1'b0;
        set_timer_two_external_flag  = 1'b0;
        if (tick2)
        begin
            if (updown && !i_timer_two_direction_pin)
            begin
                if (cnt2 == rcap)
                begin
                    next_cnt2 = TTC_WORD_TOP;
                    t2_ovf    = 1'b1;
                end
                else
                begin
                    next_cnt2 = cnt2 - 16'h0001;
                end
            end
            else if (cnt2 == TTC_WORD_TOP)
            begin
                next_cnt2 = capture ? 16'h0000 : rcap;
                t2_ovf    = 1'b1;
            end
            else
            begin
                next_cnt2 = cnt2 + 16'h0001;
            end
        end
        set_tf2  = t2_ovf && !baud && !clkout;
        tog_timer_two_external_flag = t2_ovf && updown;
        if (t2_ctrl[TTC_T2_EXEN2] && fall_dir && !baud && !updown)
        begin
            set_timer_two_external_flag = 1'b1;
            if (capture)
                next_rcap = cnt2;
            else
                next_cnt2 = rcap;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            cnt2 <= 16'h0000;
            rcap <= 16'h0000;
        end
        else
        begin
            cnt2[7:0]  <= (wr_fire && i_av.address == TTC_IDX_T2_LOW) ? wdat : next_cnt2[7:0];
            cnt2[15:8] <= (wr_fire && i_av.address == TTC_IDX_T2_HIGH) ? wdat : next_cnt2[15:8];
            rcap[7:0]  <= (wr_fire && i_av.address == TTC_IDX_RELOAD_LOW) ? wdat : next_rcap[7:0];
            rcap[15:8] <= (wr_fire && i_av.address == TTC_IDX_RELOAD_HI) ? wdat : next_rcap[15:8];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            t2_ctrl <= TTC_RESET_BYTE;
        else
        begin
            if (wr_fire && i_av.address == TTC_IDX_T2_CTRL)
                t2_ctrl <= wdat;
            if (set_tf2)
                t2_ctrl[TTC_T2_TF2] <= 1'b1;
            if (tog_timer_two_external_flag)
                t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG] <= !t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG];
            else if (set_timer_two_external_flag)
                t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG] <= 1'b1;
        end
    end

    // Pin, baud and interrupt outputs.
    assign o_timer_two_io_pin_oe = t2_mode[TTC_T2M_OE];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_timer_two_io_pin <= 1'b0;
            o_rx_baud_tick     <= 1'b0;
            o_tx_baud_tick     <= 1'b0;
            o_timer_zero_irq   <= 1'b0;
            o_timer_one_irq    <= 1'b0;
            o_timer_two_irq    <= 1'b0;
        end
        else
        begin
            if (!clkout)
                o_timer_two_io_pin <= 1'b0;
            else if (t2_ovf)
                o_timer_two_io_pin <= !o_timer_two_io_pin;
            o_rx_baud_tick   <= t2_ctrl[TTC_T2_RCLK] ? t2_ovf : t1_ovf;
            o_tx_baud_tick   <= t2_ctrl[TTC_T2_TX_BAUD_FROM_TIMER_TWO] ? t2_ovf : t1_ovf;
            o_timer_zero_irq <= run_flags[TTC_RF_TF0];
            o_timer_one_irq  <= run_flags[TTC_RF_TF1];
            o_timer_two_irq  <= t2_ctrl[TTC_T2_TF2] || (t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG] && !t2_mode[TTC_T2M_UPDOWN_ENABLE]);
        end
    end

    gate_one_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (mode_ctrl[TTC_MC_TIMER_ONE_PIN_GATING] && !i_ext_irq_one_n && !wr_fire) |=> $stable({th1, tl1}))
        else $error("Timer one counted while gated off.");

    gate_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (mode_ctrl[TTC_MC_TIMER_ZERO_PIN_GATING] && !i_ext_irq_zero_n && t0_mode != TTC_MODE_SPLIT && !wr_fire)
        |=> $stable({th0, tl0}))
        else $error("Timer zero counted while gated off.");

    t1_timer_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (tick1 && !mode_ctrl[TTC_MC_CT1] && t1_mode == TTC_MODE_16 && !wr_fire)
        |=> {th1, tl1} == $past({th1, tl1}) + 16'h0001)
        else $error("Timer one did not count the divided clock.");

    t0_counter_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (mode_ctrl[TTC_MC_CT0] && !fall0 && t0_mode != TTC_MODE_SPLIT && !wr_fire) |=> $stable({th0, tl0}))
        else $error("Timer zero moved without a pin edge.");

    t0_reload_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (t0_mode == TTC_MODE_RELOAD && tick0 && tl0 == TTC_BYTE_TOP && !wr_fire)
        |=> tl0 == $past(th0) && $stable(th0) && run_flags[TTC_RF_TF0])
        else $error("Timer zero reload failed.");

    t1_halt_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (t1_mode == TTC_MODE_SPLIT && !wr_fire) [*2] |-> $stable({th1, tl1}))
        else $error("Timer one moved while halted.");

    up_ovf_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (updown && tick2 && i_timer_two_direction_pin && cnt2 == TTC_WORD_TOP && !wr_fire && !clkout)
        |=> cnt2 == $past(rcap) && t2_ctrl[TTC_T2_TF2])
        else $error("Timer two overflow did not reload.");

    down_unf_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (updown && tick2 && !i_timer_two_direction_pin && cnt2 == rcap && !wr_fire && !clkout)
        |=> cnt2 == TTC_WORD_TOP && t2_ctrl[TTC_T2_TF2])
        else $error("Timer two underflow did not load ffff.");

    ext_toggle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (tog_timer_two_external_flag && !wr_fire) |=> t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG] != $past(t2_ctrl[TTC_T2_TIMER_TWO_EXTERNAL_FLAG]))
        else $error("External flag did not toggle.");

    clkout_pin_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (clkout && t2_ovf) |=> o_timer_two_io_pin != $past(o_timer_two_io_pin))
        else $error("Clock output did not toggle on overflow.");

    t2_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!t2_ctrl[TTC_T2_TR2] && !wr_fire && !set_timer_two_external_flag) |=> $stable(cnt2))
        else $error("Timer two moved while stopped.");

endmodule : ttc_timers

// File: sim/tb_top.sv
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module tb_top;
    import ttc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    ttc_av_req_s av     = '0;
    logic [2:0]  pul    = 3'h0;
    logic [1:0]  gate_n = 2'h3;
    logic        dir    = 1'b1;
    logic [2:0]  cnt_pin;
    logic [1:0]  gpin;
    logic        dpin, wq, io, oe, irq0, irq1, irq2;
    logic [31:0] rdat, q;
    int          err_total = 0;
    int          tests_run = 0;
    int          n;
    logic        rxb, txb;
    int          n_rx = 0;
    int          n_tx = 0;
    logic [7:0]  regs [12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
                               8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd};

    always #20 clk = ~clk;

    ttc_pin_model u_pins (
        .i_sys_clk(clk), .i_pulse(pul), .i_gate_n(gate_n), .i_dir(dir),
        .o_count_pin(cnt_pin), .o_gate_n(gpin), .o_dir(dpin)
    );

    ttc_timers u_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_av(av), .o_waitrequest(wq), .o_readdata(q),
        .i_ext_irq_zero_n(gpin[0]), .i_ext_irq_one_n(gpin[1]),
        .i_timer_zero_count_pin(cnt_pin[0]), .i_timer_one_count_pin(cnt_pin[1]),
        .i_timer_two_io_pin(cnt_pin[2]), .i_timer_two_direction_pin(dpin),
        .o_timer_two_io_pin(io), .o_timer_two_io_pin_oe(oe),
        .o_rx_baud_tick(rxb), .o_tx_baud_tick(txb),
        .o_timer_zero_irq(irq0), .o_timer_one_irq(irq1), .o_timer_two_irq(irq2)
    );

    // Counts the one-cycle baud pulses handed to the serial port.
    always @(posedge clk)
    begin
        if (rxb === 1'b1)
            n_rx++;
        if (txb === 1'b1)
            n_tx++;
    end

    // One bus transfer, entered just after a clock edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        av <= '{read: !w, write: w, address: a, writedata: {24'h0, d}, byteenable: 4'hf};
        @(posedge clk);
        for (int i = 0; i < 50 && wq !== 1'b0; i++) @(posedge clk);
        rdat = q;
        av <= '0;
        @(posedge clk);
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        `CHK(nm, {24'h0, e}, rdat)
    endtask : rdc

    // Requests k falling edges on count pin b.
    task automatic pls(input int b, input int k);
        repeat (k)
        begin
            pul[b] <= 1'b1;
            @(posedge clk);
            pul[b] <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask : pls

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (regs[i]) rdc(regs[i], 8'h00, "reset value");
        bus(1'b1, 8'h10, 8'h55);
        rdc(8'h10, 8'h00, "unmapped");
        // Timer zero, cascaded counter on its pin.
        bus(1'b1, 8'h89, 8'h05);
        bus(1'b1, 8'h8a, 8'hfe);
        bus(1'b1, 8'h88, 8'h10);
        pls(0, 3);
        rdc(8'h8a, 8'h01, "t0 low");
        rdc(8'h8c, 8'h01, "t0 high");
        bus(1'b1, 8'h89, 8'h0d);
        gate_n <= 2'h2;
        pls(0, 2);
        rdc(8'h8a, 8'h01, "t0 gated");
        gate_n <= 2'h3;
        pls(0, 1);
        rdc(8'h8a, 8'h02, "t0 ungated");
        // Timer zero prescaled mode.
        bus(1'b1, 8'h88, 8'h00);
        bus(1'b1, 8'h89, 8'h04);
        bus(1'b1, 8'h8a, 8'h1f);
        bus(1'b1, 8'h8c, 8'h10);
        bus(1'b1, 8'h88, 8'h10);
        pls(0, 2);
        rdc(8'h8a, 8'h01, "t0 prescaler");
        rdc(8'h8c, 8'h11, "t0 high");
        // Timer zero auto-reload.
        bus(1'b1, 8'h88, 8'h00);
        bus(1'b1, 8'h89, 8'h06);
        bus(1'b1, 8'h8c, 8'h80);
        bus(1'b1, 8'h8a, 8'hfe);
        bus(1'b1, 8'h88, 8'h10);
        pls(0, 3);
        rdc(8'h8a, 8'h81, "t0 reload");
        rdc(8'h8c, 8'h80, "t0 high kept");
        rdc(8'h88, 8'h30, "run flags");
        `CHK("t0 irq", 1'b1, irq0)
        // Timer one auto-reload, then halt.
        bus(1'b1, 8'h89, 8'h60);
        bus(1'b1, 8'h8d, 8'h40);
        bus(1'b1, 8'h8b, 8'hff);
        bus(1'b1, 8'h88, 8'h40);
        pls(1, 2);
        rdc(8'h8b, 8'h41, "t1 reload");
        rdc(8'h8d, 8'h40, "t1 high kept");
        rdc(8'h88, 8'hc0, "run flags");
        `CHK("t1 irq", 1'b1, irq1)
        `CHK("rx baud from t1", 1, n_rx)
        `CHK("tx baud from t1", 1, n_tx)
        bus(1'b1, 8'h89, 8'h70);
        pls(1, 2);
        rdc(8'h8b, 8'h41, "t1 halted");
        // Timer zero split, high byte idle without timer one run.
        bus(1'b1, 8'h88, 8'h00);
        bus(1'b1, 8'h89, 8'h07);
        bus(1'b1, 8'h8a, 8'h00);
        bus(1'b1, 8'h8c, 8'h00);
        bus(1'b1, 8'h88, 8'h10);
        pls(0, 2);
        rdc(8'h8a, 8'h02, "split low");
        rdc(8'h8c, 8'h00, "split high");
        // Timer two up/down counter on its pin.
        bus(1'b1, 8'hc8, 8'h02);
        bus(1'b1, 8'hc9, 8'h01);
        bus(1'b1, 8'hca, 8'h34);
        bus(1'b1, 8'hcb, 8'h12);
        bus(1'b1, 8'hcc, 8'hfe);
        bus(1'b1, 8'hcd, 8'hff);
        bus(1'b1, 8'hc8, 8'h06);
        pls(2, 2);
        rdc(8'hcc, 8'h34, "t2 low");
        rdc(8'hcd, 8'h12, "t2 high");
        rdc(8'hc8, 8'hc6, "t2 control");
        `CHK("t2 irq", 1'b1, irq2)
        bus(1'b1, 8'hc8, 8'h46);
        dir <= 1'b0;
        pls(2, 1);
        rdc(8'hcc, 8'hff, "t2 low");
        rdc(8'hcd, 8'hff, "t2 high");
        rdc(8'hc8, 8'h86, "t2 control");
        // Timer two clock output, set up in the documented order.
        bus(1'b1, 8'hc8, 8'h00);
        bus(1'b1, 8'hc9, 8'h02);
        bus(1'b1, 8'hca, 8'hfc);
        bus(1'b1, 8'hcb, 8'hff);
        bus(1'b1, 8'hcc, 8'hfc);
        bus(1'b1, 8'hcd, 8'hff);
        bus(1'b1, 8'hc8, 8'h04);
        `CHK("pin enable", 1'b1, oe)
        for (n = 0; n < 100 && io !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 100 && io === 1'b1; n++) @(posedge clk);
        `CHK("clock high time", 8, n)
        for (n = 0; n < 100 && io !== 1'b1; n++) @(posedge clk);
        `CHK("clock low time", 8, n)
        rdc(8'hc8, 8'h04, "no t2 flag");
        `CHK("t2 irq", 1'b0, irq2)
        `CHK("rx baud total", 1, n_rx)
        `CHK("tx baud total", 1, n_tx)
        stop_test();
    end
endmodule : tb_top

// File: sim/ttc_pin_model.sv
module ttc_pin_model (
    input  wire logic       i_sys_clk,
    input  wire logic [2:0] i_pulse,
    input  wire logic [1:0] i_gate_n,
    input  wire logic       i_dir,
    output logic [2:0]      o_count_pin,
    output logic [1:0]      o_gate_n,
    output logic            o_dir
);
    timeunit 1ns;
    timeprecision 1ns;

    // Count pins rest high and dip low for one cycle per requested event.
    always_ff @(posedge i_sys_clk)
    begin
        o_count_pin <= ~i_pulse;
    end

    // Gate and direction levels follow the bench one cycle later.
    always_ff @(posedge i_sys_clk)
    begin
        o_gate_n <= i_gate_n;
        o_dir    <= i_dir;
    end
endmodule : ttc_pin_model
